// file: logic/press_cycle_output_logic.sv
// Press cycle release, request and error logic with APB register file
`timescale 1ns/1ps
module press_cycle_output_logic #(
	parameter int MS_TICK_CYCLES = press_cycle_pkg::MS_CYCLES
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire press_cycle_pkg::press_in_type press_in, // Press and light curtain inputs
	output press_cycle_pkg::press_out_type press_out, // Release and status outputs
	output logic irq // Level interrupt
);
	import press_cycle_pkg::*;

	press_cfg_type cfg;
	press_state_type state;
	press_state_type next_state;
	logic [IRQ_BITS-1:0] irq_stat;
	logic [IRQ_BITS-1:0] irq_en;
	logic [31:0] tick_cnt;
	logic ms_tick;
	logic start_prev;
	logic cycle_prev;
	logic top_prev;
	logic [15:0] start_ms;
	logic [15:0] cycle_low_ms;
	logic [15:0] seq_ms;
	logic [15:0] mute_ms;
	logic [3:0] cycles_seen;
	logic start_ok;
	logic cycle_ok;
	logic cycle_rise;
	logic cycle_timeout;
	logic intrusion;
	logic wrong_pos;

	// Time base
	wire tick_wrap = (tick_cnt == 32'(MS_TICK_CYCLES - 1));

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tick_cnt <= 32'h0;
			ms_tick <= 1'b0;
		end else begin
			tick_cnt <= tick_wrap ? 32'h0 : tick_cnt + 32'h1;
			ms_tick <= tick_wrap;
		end
	end

	// Start and cycle pulse qualification
	wire [15:0] pulse_min = cfg.long_pulse ? PULSE_MIN_LONG_MS : PULSE_MIN_SHORT_MS;
	wire start_fall = start_prev & ~press_in.start;
	wire start_valid = start_fall & (start_ms >= pulse_min) & (start_ms <= PULSE_MAX_MS);
	wire cycle_rise_now = ~cycle_prev & press_in.cycle;
	wire cycle_valid = cycle_rise_now & (cycle_low_ms >= pulse_min);
	wire top_rise = ~top_prev & press_in.top;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			start_prev <= 1'b0;
			cycle_prev <= 1'b1;
			// Top idles high at the dead centre, so no false rise after reset
			top_prev <= 1'b1;
			start_ms <= 16'h0;
			cycle_low_ms <= 16'h0;
			start_ok <= 1'b0;
			cycle_ok <= 1'b0;
			cycle_rise <= 1'b0;
		end else begin
			start_prev <= press_in.start;
			cycle_prev <= press_in.cycle;
			top_prev <= press_in.top;
			if (!press_in.start)
				start_ms <= 16'h0;
			else if (ms_tick && start_ms <= PULSE_MAX_MS)
				start_ms <= start_ms + 16'h1;
			if (press_in.cycle)
				cycle_low_ms <= 16'h0;
			else if (ms_tick && cycle_low_ms <= PULSE_MAX_MS)
				cycle_low_ms <= cycle_low_ms + 16'h1;
			start_ok <= start_valid;
			cycle_ok <= cycle_valid;
			cycle_rise <= cycle_rise_now;
		end
	end

	// Startup muting bypasses the cycle input during the startup stroke
	wire mute_en = (cfg.mute_max != 16'h0);
	wire muted = mute_en & press_in.startup & ~press_in.top & (mute_ms < cfg.mute_max);
	wire cycle_clear = press_in.cycle | muted;

	// Sequence conditions
	wire start_gate = ~cfg.start_rel_en | press_in.start_release;
	wire start_taken = (state == ST_START) & start_ok & press_in.static_release
		& start_gate & ~wrong_pos;
	wire cycles_done = (cycles_seen >= cfg.cycle_count);
	wire limit_hit = (cfg.cycle_limit != 16'h0) & (seq_ms >= cfg.cycle_limit);
	wire run_stop = (state == ST_RUN) & (~press_in.static_release | ~cycle_clear);
	wire bad_cycle = (state == ST_RUN) & ~cycle_clear;
	wire stroke_end = (state == ST_RUN) & top_rise;
	wire intr_start_only = (cfg.interlock == INTERLOCK_ALWAYS)
		| ((cfg.interlock == INTERLOCK_NEVER) & mute_en);
	wire need_start = (cfg.interlock == INTERLOCK_ALWAYS)
		| ((cfg.interlock == INTERLOCK_DOWNSTROKE) & ~press_in.top)
		| (bad_cycle & intr_start_only);
	wire go_run = (state == ST_CYCLE) & cycles_done & press_in.static_release
		& press_in.cycle & ~wrong_pos & ~cycle_timeout & ~limit_hit;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_START: begin
				if (start_taken)
					next_state = ST_CYCLE;
			end
			ST_CYCLE: begin
				if (limit_hit)
					next_state = ST_START;
				else if (go_run)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (run_stop)
					next_state = need_start ? ST_START : ST_CYCLE;
				else if (stroke_end)
					next_state = (cfg.interlock == INTERLOCK_ALWAYS) ? ST_START : ST_CYCLE;
			end
			default: next_state = ST_START;
		endcase
	end

	// Error and position flags; a set in the same cycle wins over the clear
	wire intr_ack_edge = (cfg.interlock == INTERLOCK_NEVER) & ~mute_en & cycle_rise;
	wire intr_ack_cycles = (cfg.interlock == INTERLOCK_DOWNSTROKE) & go_run;
	wire intr_clear = start_taken | intr_ack_edge | intr_ack_cycles;
	wire wrong_set = run_stop & ~press_in.top;
	wire wrong_clear = press_in.top & ~press_in.drive_release;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state <= ST_START;
			cycle_timeout <= 1'b0;
			intrusion <= 1'b0;
			wrong_pos <= 1'b0;
		end else begin
			state <= next_state;
			if (limit_hit && state == ST_CYCLE)
				cycle_timeout <= 1'b1;
			else if (start_taken)
				cycle_timeout <= 1'b0;
			if (bad_cycle)
				intrusion <= 1'b1;
			else if (intr_clear)
				intrusion <= 1'b0;
			if (wrong_set)
				wrong_pos <= 1'b1;
			else if (wrong_clear)
				wrong_pos <= 1'b0;
		end
	end

	// Sequence timer, cycle counter and muting timer
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			seq_ms <= 16'h0;
			cycles_seen <= 4'h0;
			mute_ms <= 16'h0;
		end else begin
			if (state != ST_CYCLE)
				seq_ms <= 16'h0;
			else if (ms_tick && seq_ms != 16'hffff)
				seq_ms <= seq_ms + 16'h1;
			if (state != ST_CYCLE)
				cycles_seen <= 4'h0;
			else if (cycle_ok && !cycles_done)
				cycles_seen <= cycles_seen + 4'h1;
			if (!press_in.startup || press_in.top)
				mute_ms <= 16'h0;
			else if (ms_tick && mute_ms != 16'hffff)
				mute_ms <= mute_ms + 16'h1;
		end
	end

	// Output stage
	wire errors = cycle_timeout | intrusion;
	wire next_start_req = (next_state == ST_START);
	wire next_release = (next_state == ST_RUN) & press_in.static_release & cycle_clear
		& ~errors & ~next_start_req;
	wire next_cycle_req = (next_state == ST_CYCLE) & ~cycles_done;
	wire next_timeout = (limit_hit & state == ST_CYCLE) | (cycle_timeout & ~start_taken);
	wire next_intr = bad_cycle | (intrusion & ~intr_clear);
	wire next_err = cfg.err_en & (next_timeout | next_intr);
	wire next_wrong = wrong_set | (wrong_pos & ~wrong_clear);

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			press_out <= '0;
			press_out.start_req <= 1'b1;
		end else begin
			press_out.release_out <= next_release;
			press_out.start_req <= next_start_req;
			press_out.cycle_req <= next_cycle_req;
			press_out.cycle_timeout <= next_timeout;
			press_out.intrusion <= next_intr;
			press_out.wrong_pos <= next_wrong;
			press_out.error_flag <= next_err;
		end
	end

	// APB slave, one wait-free access phase
	wire setup = psel & ~penable & ~pready;
	wire access = psel & penable & pready;
	wire wr = access & pwrite;
	wire hit_ctrl = (paddr == OFS_CTRL);
	wire hit_limit = (paddr == OFS_CYCLE_LIMIT);
	wire hit_count = (paddr == OFS_CYCLE_COUNT);
	wire hit_mute = (paddr == OFS_MUTE_MAX);
	wire hit_status = (paddr == OFS_STATUS);
	wire hit_istat = (paddr == OFS_IRQ_STAT);
	wire hit_iclr = (paddr == OFS_IRQ_CLR);
	wire hit_ien = (paddr == OFS_IRQ_EN);
	wire mapped = hit_ctrl | hit_limit | hit_count | hit_mute | hit_status
		| hit_istat | hit_iclr | hit_ien;
	wire [31:0] ctrl_word = {27'h0, cfg.start_rel_en, cfg.err_en, cfg.long_pulse,
		cfg.interlock};
	wire [31:0] status_word = {23'h0, state, press_out};
	wire [31:0] rd_word = hit_ctrl ? ctrl_word
		: hit_limit ? {16'h0, cfg.cycle_limit}
		: hit_count ? {28'h0, cfg.cycle_count}
		: hit_mute ? {16'h0, cfg.mute_max}
		: hit_status ? status_word
		: hit_istat ? {28'h0, irq_stat}
		: hit_ien ? {28'h0, irq_en}
		: 32'h0;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= (setup && !pwrite) ? rd_word : 32'h0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cfg.interlock <= RST_INTERLOCK;
			cfg.long_pulse <= 1'b0;
			cfg.err_en <= 1'b1;
			cfg.start_rel_en <= 1'b0;
			cfg.cycle_limit <= RST_CYCLE_LIMIT;
			cfg.cycle_count <= RST_CYCLE_COUNT;
			cfg.mute_max <= RST_MUTE_MAX;
		end else if (wr) begin
			if (hit_ctrl) begin
				cfg.interlock <= pwdata[CTRL_INTERLOCK_LSB +: 2];
				cfg.long_pulse <= pwdata[CTRL_LONG_PULSE_BIT];
				cfg.err_en <= pwdata[CTRL_ERR_EN_BIT];
				cfg.start_rel_en <= pwdata[CTRL_START_REL_EN_BIT];
			end
			if (hit_limit)
				cfg.cycle_limit <= pwdata[15:0];
			if (hit_count)
				cfg.cycle_count <= pwdata[3:0];
			if (hit_mute)
				cfg.mute_max <= pwdata[15:0];
		end
	end

	// Sticky events, write-one-to-clear; a new event wins over the clear
	logic [IRQ_BITS-1:0] events;
	assign events[EV_TIMEOUT] = next_timeout & ~press_out.cycle_timeout;
	assign events[EV_INTRUSION] = next_intr & ~press_out.intrusion;
	assign events[EV_WRONG_POS] = next_wrong & ~press_out.wrong_pos;
	assign events[EV_START_OK] = start_taken;
	wire [IRQ_BITS-1:0] clr_mask = (wr & hit_iclr) ? pwdata[IRQ_BITS-1:0] : '0;
	wire [IRQ_BITS-1:0] next_irq_stat = (irq_stat & ~clr_mask) | events;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			irq_stat <= '0;
			irq_en <= '0;
			irq <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			if (wr && hit_ien)
				irq_en <= pwdata[IRQ_BITS-1:0];
			irq <= |(next_irq_stat & irq_en);
		end
	end

endmodule

// file: logic/press_cycle_pkg.sv
// Package with register map, field layout, timing constants and carriers of the press cycle block
package press_cycle_pkg;

	// Clock and time base
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

	// Start and cycle pulse limits in milliseconds
	localparam logic [15:0] PULSE_MIN_SHORT_MS = 16'd100;
	localparam logic [15:0] PULSE_MIN_LONG_MS = 16'd350;
	localparam logic [15:0] PULSE_MAX_MS = 16'd30000;

	// Restart interlock codes
	localparam logic [1:0] INTERLOCK_NEVER = 2'h1;
	localparam logic [1:0] INTERLOCK_ALWAYS = 2'h2;
	localparam logic [1:0] INTERLOCK_DOWNSTROKE = 2'h3;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CYCLE_LIMIT = 8'h04;
	localparam logic [7:0] OFS_CYCLE_COUNT = 8'h08;
	localparam logic [7:0] OFS_MUTE_MAX = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
	localparam logic [7:0] OFS_IRQ_EN = 8'h1c;

	// Control register fields
	localparam int CTRL_INTERLOCK_LSB = 0;
	localparam int CTRL_LONG_PULSE_BIT = 2;
	localparam int CTRL_ERR_EN_BIT = 3;
	localparam int CTRL_START_REL_EN_BIT = 4;

	// Reset values
	localparam logic [1:0] RST_INTERLOCK = INTERLOCK_ALWAYS;
	localparam logic [15:0] RST_CYCLE_LIMIT = 16'h7530;
	localparam logic [3:0] RST_CYCLE_COUNT = 4'h1;
	localparam logic [15:0] RST_MUTE_MAX = 16'h0000;

	// Event bits of the interrupt registers
	localparam int IRQ_BITS = 4;
	localparam int EV_TIMEOUT = 0;
	localparam int EV_INTRUSION = 1;
	localparam int EV_WRONG_POS = 2;
	localparam int EV_START_OK = 3;

	typedef enum logic [1:0] {
		ST_START = 2'b00,
		ST_CYCLE = 2'b01,
		ST_RUN = 2'b10
	} press_state_type;

	typedef struct packed {
		logic static_release;
		logic start_release;
		logic cycle;
		logic top;
		logic startup;
		logic start;
		logic drive_release;
	} press_in_type;

	typedef struct packed {
		logic release_out;
		logic start_req;
		logic cycle_req;
		logic cycle_timeout;
		logic intrusion;
		logic wrong_pos;
		logic error_flag;
	} press_out_type;

	typedef struct packed {
		logic [1:0] interlock;
		logic long_pulse;
		logic err_en;
		logic start_rel_en;
		logic [15:0] cycle_limit;
		logic [3:0] cycle_count;
		logic [15:0] mute_max;
	} press_cfg_type;

endpackage

// file: test/press_cycle_output_logic_tb.sv
// Self-checking bench for the press cycle output logic
`timescale 1ns/1ps
module press_cycle_output_logic_tb;
	import press_cycle_pkg::*;
	localparam int TICK = 10;
	localparam int STROKE = 200;
	localparam int MSV = 1100;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	press_in_type press_in;
	press_out_type press_out;
	logic static_ok = 1'b1;
	logic clear = 1'b1;
	logic start_btn = 1'b0;
	logic jog = 1'b1;
	logic [31:0] rd;
	logic [31:0] v;
	logic err;
	int error_cnt = 0;
	int check_count = 0;
	logic [7:0] ofs_q[$] = '{OFS_CTRL, OFS_CYCLE_LIMIT, OFS_CYCLE_COUNT, OFS_MUTE_MAX};
	logic [31:0] rst_q[$] = '{32'h0000000a, 32'h00007530, 32'h00000001, 32'h0};
	press_cycle_output_logic #(.MS_TICK_CYCLES(TICK)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .press_in(press_in),
		.press_out(press_out), .irq(irq));
	press_env_model #(.STROKE(STROKE)) i_env (.clk_sys(clk_sys), .static_ok(static_ok),
		.clear(clear), .start_btn(start_btn), .jog(jog), .release_out(press_out.release_out),
		.press_in(press_in));
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(input logic [6:0] mask, input logic [6:0] exp);
		check_count++;
		if ((press_out & mask) !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t outputs %b expected %b", $time, press_out & mask, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic pulse_start(input int n);
		start_btn <= 1'b1;
		tick(n);
		start_btn <= 1'b0;
		tick(4);
	endtask
	task automatic intervene(input int n);
		clear <= 1'b0;
		tick(n);
		clear <= 1'b1;
		tick(4);
	endtask
	task automatic run_up;
		pulse_start(MSV);
		chk_out(7'h7f, 7'h10);
		intervene(MSV);
		chk_out(7'h7f, 7'h40);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		tick(60000);
		error_cnt++;
		$display("MISMATCH %0t watchdog expired", $time);
		summarize();
	end
	initial begin
		rd = $urandom(32'hd416);
		tick(12);
		rst_b <= 1'b1;
		jog <= 1'b0;
		tick(2);
		chk_out(7'h7f, 7'h20);
		foreach (ofs_q[i]) begin
			apb(1'b0, ofs_q[i], 32'h0);
			chk_word(rd, rst_q[i]);
		end
		apb(1'b0, 8'h24, 32'h0);
		chk_word({31'h0, err}, 32'h1);
		for (int c = 1; c < 4; c++) begin
			apb(1'b1, OFS_CTRL, 32'h8 | 32'(c));
			apb(1'b0, OFS_CTRL, 32'h0);
			chk_word(rd, 32'h8 | 32'(c));
		end
		v = $urandom & 32'h0000ffff;
		apb(1'b1, OFS_CYCLE_LIMIT, v);
		apb(1'b0, OFS_CYCLE_LIMIT, 32'h0);
		chk_word(rd, v);
		apb(1'b1, OFS_CYCLE_LIMIT, 32'h0);
		apb(1'b1, OFS_CTRL, 32'ha);
		$display("test registers done");
		pulse_start(500);
		chk_out(7'h30, 7'h20);
		run_up();
		tick(STROKE + 20);
		chk_out(7'h7f, 7'h20);
		run_up();
		tick(20);
		static_ok <= 1'b0;
		tick(2);
		chk_out(7'h40, 7'h00);
		tick(3);
		chk_out(7'h02, 7'h02);
		static_ok <= 1'b1;
		pulse_start(MSV);
		chk_out(7'h42, 7'h02);
		jog <= 1'b1;
		tick(2);
		jog <= 1'b0;
		tick(3);
		chk_out(7'h02, 7'h00);
		$display("test stop and position done");
		apb(1'b1, OFS_CTRL, 32'h9);
		run_up();
		tick(STROKE + 20);
		chk_out(7'h7f, 7'h10);
		intervene(MSV);
		chk_out(7'h7f, 7'h40);
		apb(1'b1, OFS_CTRL, 32'ha);
		apb(1'b1, OFS_IRQ_EN, 32'h2);
		clear <= 1'b0;
		tick(3);
		chk_out(7'h45, 7'h05);
		tick(2);
		chk_word({31'h0, irq}, 32'h1);
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk_word(rd & 32'h2, 32'h2);
		apb(1'b1, OFS_IRQ_CLR, 32'h2);
		tick(2);
		chk_word({31'h0, irq}, 32'h0);
		clear <= 1'b1;
		apb(1'b1, OFS_CYCLE_LIMIT, 32'h5);
		jog <= 1'b1;
		tick(2);
		jog <= 1'b0;
		pulse_start(MSV);
		chk_out(7'h7f, 7'h10);
		$display("test interlock and intrusion done");
		tick(60);
		chk_out(7'h79, 7'h29);
		pulse_start(500);
		chk_out(7'h08, 7'h08);
		pulse_start(MSV);
		chk_out(7'h08, 7'h00);
		$display("test timeout done");
		apb(1'b1, OFS_CYCLE_LIMIT, 32'h0);
		apb(1'b1, OFS_CTRL, 32'hb);
		intervene(MSV);
		chk_out(7'h7f, 7'h40);
		tick(20);
		clear <= 1'b0;
		tick(3);
		chk_out(7'h64, 7'h24);
		clear <= 1'b1;
		$display("test downstroke interlock done");
		summarize();
	end
endmodule

// file: test/press_cycle_sva.sv
// Port assertions for the press cycle output logic
`timescale 1ns/1ps
module press_cycle_sva (
	input wire logic clk_sys, // System clock
	input wire logic rst_b, // Synchronous reset, active low
	input wire press_cycle_pkg::press_in_type press_in, // Press inputs
	input wire press_cycle_pkg::press_out_type press_out // Press outputs
);
	import press_cycle_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	property p_rel_start;
		press_out.release_out |-> !press_out.start_req;
	endproperty
	a_rel_start: assert property (p_rel_start) else $error("release with start request");
	property p_static;
		!press_in.static_release |=> !press_out.release_out;
	endproperty
	a_static: assert property (p_static) else $error("release kept without static");
	property p_err_hold;
		press_out.cycle_timeout || press_out.intrusion |-> !press_out.release_out;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("release during error");
	property p_err_src;
		press_out.error_flag |-> press_out.cycle_timeout || press_out.intrusion;
	endproperty
	a_err_src: assert property (p_err_src) else $error("error flag without cause");
	property p_reset;
		disable iff (1'b0) !rst_b |=> press_out.start_req && !press_out.release_out;
	endproperty
	a_reset: assert property (p_reset) else $error("wrong reset outputs");
	property p_intr;
		press_out.release_out && !press_in.cycle && !press_in.startup |=> press_out.intrusion;
	endproperty
	a_intr: assert property (p_intr) else $error("intervention not flagged");
	property p_start_fall;
		$fell(press_out.start_req) |->
			$past(press_in.start, 2) || $past(press_in.start, 3) || $past(press_in.start, 4);
	endproperty
	a_start_fall: assert property (p_start_fall) else $error("start request fell alone");
	property p_to_clear;
		$fell(press_out.cycle_timeout) |-> !press_out.start_req;
	endproperty
	a_to_clear: assert property (p_to_clear) else $error("timeout cleared without start");
endmodule
bind press_cycle_output_logic press_cycle_sva i_sva (.clk_sys(clk_sys), .rst_b(rst_b),
	.press_in(press_in), .press_out(press_out));

// file: test/press_env_model.sv
// Behavioural press drive and light curtain that feed the block inputs
`timescale 1ns/1ps
module press_env_model #(
	parameter int STROKE = 200
) (
	input wire logic clk_sys, // System clock
	input wire logic static_ok, // Main release from contact monitor
	input wire logic clear, // Protective field free
	input wire logic start_btn, // Start button
	input wire logic jog, // Setup mode move back to top
	input wire logic release_out, // Release from the block
	output press_cycle_pkg::press_in_type press_in // Block inputs
);
	import press_cycle_pkg::*;
	int pos;
	logic drive;
	always_ff @(posedge clk_sys) begin
		drive <= release_out;
		if (jog)
			pos <= 0;
		else if (drive && pos < STROKE)
			pos <= pos + 1;
		else if (!drive && pos >= STROKE)
			pos <= 0;
	end
	// Top stays high from the end of the stroke until the drive has stopped
	assign press_in = '{static_release: static_ok, start_release: 1'b1, cycle: clear,
		top: (pos == 0 || pos >= STROKE), startup: 1'b0, start: start_btn, drive_release: drive};
endmodule
